/* logic/pec_error_capture.sv */
`timescale 1ns/1ps
module pec_error_capture #(
	parameter logic [15:0] HIGHEST_PARTITION_INDEX = 16'h003F,
	parameter logic [7:0] PMG_MAX = 8'h01,
	parameter logic [15:0] MONITOR_MAX = 16'h0007,
	parameter logic [15:0] INTERNAL_ID_MAX = 16'h000F,
	parameter logic [3:0] RIS_MAX = 4'h1,
	parameter bit INSTANCE_SELECT_PRESENT = 1'b1,
	parameter bit WIDENED_ID_PRESENT = 1'b1,
	parameter bit REALM_FEATURE_PRESENT = 1'b1
) (
	input wire logic clk,
	input wire logic reset_n,
	// Register access port
	input wire logic [1:0] reg_space,
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [63:0] reg_wdata,
	output logic [63:0] reg_rdata,
	output logic reg_rvalid,
	// Interrupts, one per space
	input wire logic [pec_pkg::PEC_SP_N-1:0] error_irq_enable,
	output logic [pec_pkg::PEC_SP_N-1:0] error_irq,
	// Partition select register write
	input wire logic psel_wr,
	input wire logic [1:0] psel_space,
	input wire logic [15:0] psel_partition_id,
	input wire logic psel_internal,
	input wire logic [3:0] psel_ris,
	// Partition configuration access
	input wire logic cfg_acc,
	input wire logic [1:0] cfg_space,
	input wire logic [15:0] cfg_partition_id,
	input wire logic cfg_internal,
	input wire logic [3:0] cfg_ris,
	input wire logic cfg_to_intmap,
	input wire logic cfg_intmap_wr,
	input wire logic [15:0] cfg_internal_id,
	input wire logic cfg_has_control,
	// Monitor select register write
	input wire logic msel_wr,
	input wire logic [1:0] msel_space,
	input wire logic [15:0] msel_monitor_selector,
	input wire logic [3:0] msel_ris,
	// Monitor configuration write
	input wire logic mcfg_wr,
	input wire logic [1:0] mcfg_space,
	input wire logic [15:0] mcfg_partition_id,
	input wire logic [7:0] mcfg_monitoring_group,
	input wire logic [3:0] mcfg_ris,
	// Monitor register access
	input wire logic macc,
	input wire logic [1:0] macc_space,
	input wire logic [15:0] macc_monitor_selector,
	input wire logic [3:0] macc_ris,
	input wire logic macc_has_type,
	// Tagged request and its forwarded copy
	input wire logic req_valid,
	input wire logic [1:0] req_space,
	input wire logic [15:0] req_partition_id,
	input wire logic [7:0] req_monitoring_group,
	output logic fwd_valid,
	output logic [15:0] fwd_partition_id,
	output logic [7:0] fwd_monitoring_group
);
	import pec_pkg::*;

	// RESOURCE_INSTANCE_SELECTOR is only kept when both the selector and the wide layout exist
	localparam bit RIS_KEEP = INSTANCE_SELECT_PRESENT & WIDENED_ID_PRESENT;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Value above its implemented maximum
	function automatic logic over16(
		input logic [15:0] v,
		input logic [15:0] lim
	);
		return v > lim;
	endfunction

	// Selector value with no resource instance behind it
	function automatic logic bad_ris(input logic [3:0] r);
		return INSTANCE_SELECT_PRESENT && (r > RIS_MAX);
	endfunction

	// Root and realm frames answer only with the realm feature
	function automatic logic space_on(input logic [1:0] sp);
		return (sp == PEC_SP_S) || (sp == PEC_SP_NS) ||
			REALM_FEATURE_PRESENT;
	endfunction

	// The status register hit in a given frame
	function automatic logic esr_hit(
		input logic [1:0] sp,
		input logic [15:0] a
	);
		return (a == PEC_ESR_OFFSET) && space_on(sp);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Candidate errors, one per source; code NONE carries no fields

	logic [PEC_SRC_N-1:0] c_v;
	logic [1:0] c_sp [PEC_SRC_N];
	logic [3:0] c_code [PEC_SRC_N];
	logic [15:0] c_id [PEC_SRC_N];
	logic [7:0] c_pmg [PEC_SRC_N];
	logic [3:0] c_ris [PEC_SRC_N];

	// Range flags on the request path, shared with forwarding
	logic req_id_bad;
	logic req_pmg_bad;

	assign req_id_bad = over16(req_partition_id, HIGHEST_PARTITION_INDEX);
	assign req_pmg_bad = req_monitoring_group > PMG_MAX;

	// Partition select write: range first, then instance selector
	always_comb begin
		c_sp[PEC_SRC_PSEL] = psel_space;
		c_id[PEC_SRC_PSEL] = psel_partition_id;
		c_pmg[PEC_SRC_PSEL] = 8'h00;
		c_ris[PEC_SRC_PSEL] = psel_ris;
		c_code[PEC_SRC_PSEL] = PEC_ERR_NONE;
		if (!psel_wr) begin
			c_code[PEC_SRC_PSEL] = PEC_ERR_NONE;
		end else if (!psel_internal &&
			over16(psel_partition_id, HIGHEST_PARTITION_INDEX)) begin
			c_code[PEC_SRC_PSEL] = PEC_ERR_PSEL_RANGE;
		end else if (bad_ris(psel_ris)) begin
			c_code[PEC_SRC_PSEL] = PEC_ERR_PSEL_RIS;
		end
	end

	// Partition configuration access: wrong flag, internal range,
	// then a missing control on the selected instance
	always_comb begin
		c_sp[PEC_SRC_CFG] = cfg_space;
		c_id[PEC_SRC_CFG] = cfg_partition_id;
		c_pmg[PEC_SRC_CFG] = 8'h00;
		c_ris[PEC_SRC_CFG] = 4'h0;
		c_code[PEC_SRC_CFG] = PEC_ERR_NONE;
		if (!cfg_acc) begin
			c_code[PEC_SRC_CFG] = PEC_ERR_NONE;
		end else if (cfg_to_intmap && cfg_internal) begin
			c_code[PEC_SRC_CFG] = PEC_ERR_UNEXP_INT;
		end else if (cfg_intmap_wr &&
			over16(cfg_internal_id, INTERNAL_ID_MAX)) begin
			c_code[PEC_SRC_CFG] = PEC_ERR_INT_RANGE;
			c_id[PEC_SRC_CFG] = cfg_internal_id;
		end else if (!cfg_has_control) begin
			c_code[PEC_SRC_CFG] = PEC_ERR_NO_CTRL;
			c_ris[PEC_SRC_CFG] = cfg_ris;
		end
	end

	// Monitor select write: selector range, then instance selector
	always_comb begin
		c_sp[PEC_SRC_MSEL] = msel_space;
		c_id[PEC_SRC_MSEL] = msel_monitor_selector;
		c_pmg[PEC_SRC_MSEL] = 8'h00;
		c_ris[PEC_SRC_MSEL] = msel_ris;
		c_code[PEC_SRC_MSEL] = PEC_ERR_NONE;
		if (!msel_wr) begin
			c_code[PEC_SRC_MSEL] = PEC_ERR_NONE;
		end else if (over16(msel_monitor_selector, MONITOR_MAX)) begin
			c_code[PEC_SRC_MSEL] = PEC_ERR_MON_RANGE;
		end else if (bad_ris(msel_ris)) begin
			c_code[PEC_SRC_MSEL] = PEC_ERR_MSEL_RIS;
		end
	end

	// Monitor configuration write with a filter out of range
	always_comb begin
		c_sp[PEC_SRC_MCFG] = mcfg_space;
		c_id[PEC_SRC_MCFG] = mcfg_partition_id;
		c_pmg[PEC_SRC_MCFG] = mcfg_monitoring_group;
		c_ris[PEC_SRC_MCFG] = mcfg_ris;
		c_code[PEC_SRC_MCFG] = PEC_ERR_NONE;
		if (mcfg_wr && (over16(mcfg_partition_id, HIGHEST_PARTITION_INDEX)
			|| (mcfg_monitoring_group > PMG_MAX))) begin
			c_code[PEC_SRC_MCFG] = PEC_ERR_MCFG_ID;
		end
	end

	// Monitor register access to a type the instance lacks
	always_comb begin
		c_sp[PEC_SRC_MACC] = macc_space;
		c_id[PEC_SRC_MACC] = macc_monitor_selector;
		c_pmg[PEC_SRC_MACC] = 8'h00;
		c_ris[PEC_SRC_MACC] = macc_ris;
		c_code[PEC_SRC_MACC] = PEC_ERR_NONE;
		if (macc && !macc_has_type) begin
			c_code[PEC_SRC_MACC] = PEC_ERR_NO_MON;
		end
	end

	// Tagged request: identifier range outranks group range
	always_comb begin
		c_sp[PEC_SRC_REQ] = req_space;
		c_id[PEC_SRC_REQ] = req_partition_id;
		c_pmg[PEC_SRC_REQ] = req_monitoring_group;
		c_ris[PEC_SRC_REQ] = 4'h0;
		c_code[PEC_SRC_REQ] = PEC_ERR_NONE;
		if (!req_valid) begin
			c_code[PEC_SRC_REQ] = PEC_ERR_NONE;
		end else if (req_id_bad) begin
			c_code[PEC_SRC_REQ] = PEC_ERR_REQ_ID;
		end else if (req_pmg_bad) begin
			c_code[PEC_SRC_REQ] = PEC_ERR_REQ_PMG;
		end
	end

	// Only codes 1 to 11 are ever produced above
	always_comb begin
		for (int k = 0; k < PEC_SRC_N; k++) begin
			c_v[k] = c_code[k] != PEC_ERR_NONE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-space selection; the lowest source index wins, and a second
	// error in the same cycle marks the record as overwritten

	logic [PEC_SP_N-1:0] s_ev;
	logic [PEC_SP_N-1:0] s_multi;
	logic [3:0] s_code [PEC_SP_N];
	logic [15:0] s_id [PEC_SP_N];
	logic [7:0] s_pmg [PEC_SP_N];
	logic [3:0] s_ris [PEC_SP_N];

	always_comb begin
		for (int s = 0; s < PEC_SP_N; s++) begin
			s_ev[s] = 1'b0;
			s_multi[s] = 1'b0;
			s_code[s] = PEC_ERR_NONE;
			s_id[s] = 16'h0000;
			s_pmg[s] = 8'h00;
			s_ris[s] = 4'h0;
			for (int k = PEC_SRC_N - 1; k >= 0; k--) begin
				if (c_v[k] && (c_sp[k] == 2'(s))) begin
					s_multi[s] = s_multi[s] | s_ev[s];
					s_ev[s] = 1'b1;
					s_code[s] = c_code[k];
					s_id[s] = c_id[k];
					s_pmg[s] = c_pmg[k];
					s_ris[s] = c_ris[k];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status registers, one per security space

	logic [PEC_SP_N-1:0] sw_wr;
	logic [63:0] slot_status [PEC_SP_N];

	// Write strobe per frame; unmapped offsets are ignored
	always_comb begin
		for (int s = 0; s < PEC_SP_N; s++) begin
			sw_wr[s] = reg_wr && (reg_space == 2'(s)) &&
				esr_hit(reg_space, reg_addr);
		end
	end

	for (genvar g = 0; g < PEC_SP_N; g++) begin : g_slot
		// Root and realm slots stay empty without the realm feature
		localparam bit PRESENT = (g < 2) || REALM_FEATURE_PRESENT;

		pec_esr_slot #(
			.RIS_KEEP(RIS_KEEP)
		) u_slot (
			.clk(clk),
			.reset_n(reset_n),
			.present(PRESENT),
			.sw_wr(sw_wr[g]),
			.sw_wdata(reg_wdata),
			.ev(s_ev[g]),
			.ev_multi(s_multi[g]),
			.ev_code(s_code[g]),
			.ev_id(s_id[g]),
			.ev_pmg(s_pmg[g]),
			.ev_ris(s_ris[g]),
			.irq_enable(error_irq_enable[g]),
			.status(slot_status[g]),
			.irq(error_irq[g])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// Read path; each frame sees only its own register

	// Read data valid one cycle after the read strobe
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
		end
	end

	// Narrow layout hides the upper word; unmapped reads return zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 64'h0;
		end else if (!reg_rd) begin
			reg_rdata <= reg_rdata;
		end else if (esr_hit(reg_space, reg_addr)) begin
			if (WIDENED_ID_PRESENT) begin
				reg_rdata <= slot_status[reg_space];
			end else begin
				reg_rdata <= {32'h0, slot_status[reg_space][31:0]};
			end
		end else begin
			reg_rdata <= 64'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Request forwarding; an error never holds the request back, it only
	// swaps a bad identifier for zero, and zeroes the group when the identifier or the group is bad

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fwd_valid <= 1'b0;
		end else begin
			fwd_valid <= req_valid;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fwd_partition_id <= 16'h0000;
			fwd_monitoring_group <= 8'h00;
		end else if (req_valid) begin
			fwd_partition_id <= req_id_bad ? 16'h0000 :
				req_partition_id;
			fwd_monitoring_group <= (req_id_bad || req_pmg_bad) ? 8'h00 :
				req_monitoring_group;
		end
	end

endmodule

/* logic/pec_pkg.sv */
package pec_pkg;

	// Register placement in each security frame
	localparam logic [15:0] PEC_ESR_OFFSET = 16'h00F8;
	localparam logic [63:0] PEC_ESR_RESET = 64'h0;

	// Security spaces, one status register each
	localparam logic [1:0] PEC_SP_S = 2'h0;
	localparam logic [1:0] PEC_SP_NS = 2'h1;
	localparam logic [1:0] PEC_SP_RT = 2'h2;
	localparam logic [1:0] PEC_SP_RL = 2'h3;
	localparam int PEC_SP_N = 4;

	// Field layout of the status register
	localparam int PEC_ID_LSB = 0;
	localparam int PEC_PMG_LSB = 16;
	localparam int PEC_CODE_LSB = 24;
	localparam int PEC_OVR_BIT = 31;
	localparam int PEC_RIS_LSB = 32;

	// Reason codes
	localparam logic [3:0] PEC_ERR_NONE = 4'h0;
	localparam logic [3:0] PEC_ERR_PSEL_RANGE = 4'h1;
	localparam logic [3:0] PEC_ERR_REQ_ID = 4'h2;
	localparam logic [3:0] PEC_ERR_MCFG_ID = 4'h3;
	localparam logic [3:0] PEC_ERR_REQ_PMG = 4'h4;
	localparam logic [3:0] PEC_ERR_MON_RANGE = 4'h5;
	localparam logic [3:0] PEC_ERR_INT_RANGE = 4'h6;
	localparam logic [3:0] PEC_ERR_UNEXP_INT = 4'h7;
	localparam logic [3:0] PEC_ERR_PSEL_RIS = 4'h8;
	localparam logic [3:0] PEC_ERR_NO_CTRL = 4'h9;
	localparam logic [3:0] PEC_ERR_MSEL_RIS = 4'hA;
	localparam logic [3:0] PEC_ERR_NO_MON = 4'hB;

	// Error sources, lower index wins within a cycle
	localparam int PEC_SRC_PSEL = 0;
	localparam int PEC_SRC_CFG = 1;
	localparam int PEC_SRC_MSEL = 2;
	localparam int PEC_SRC_MCFG = 3;
	localparam int PEC_SRC_MACC = 4;
	localparam int PEC_SRC_REQ = 5;
	localparam int PEC_SRC_N = 6;

endpackage

/* logic/pec_esr_slot.sv */
`timescale 1ns/1ps
module pec_esr_slot #(
	parameter bit RIS_KEEP = 1'b1
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic present,
	input wire logic sw_wr,
	input wire logic [63:0] sw_wdata,
	input wire logic ev,
	input wire logic ev_multi,
	input wire logic [3:0] ev_code,
	input wire logic [15:0] ev_id,
	input wire logic [7:0] ev_pmg,
	input wire logic [3:0] ev_ris,
	input wire logic irq_enable,
	output logic [63:0] status,
	output logic irq
);
	import pec_pkg::*;

	logic [3:0] code;
	logic ovr;
	logic [15:0] id;
	logic [7:0] monitoring_group;
	logic [3:0] resource_instance_selector;

	////////////////////////////////////////////////////////////////////////
	// Reason code and overwritten flag; a hardware event beats a
	// software write in the same cycle so no error is ever lost
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			code <= PEC_ESR_RESET[PEC_CODE_LSB +: 4];
			ovr <= PEC_ESR_RESET[PEC_OVR_BIT];
		end else if (!present) begin
			code <= PEC_ERR_NONE;
			ovr <= 1'b0;
		end else if (ev) begin
			code <= ev_code;
			ovr <= (code != PEC_ERR_NONE) | ev_multi;
		end else if (sw_wr) begin
			code <= sw_wdata[PEC_CODE_LSB +: 4];
			ovr <= sw_wdata[PEC_OVR_BIT];
		end
	end

	// Captured fields follow the same precedence
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			id <= PEC_ESR_RESET[PEC_ID_LSB +: 16];
			monitoring_group <= PEC_ESR_RESET[PEC_PMG_LSB +: 8];
			resource_instance_selector <= PEC_ESR_RESET[PEC_RIS_LSB +: 4];
		end else if (!present) begin
			id <= 16'h0000;
			monitoring_group <= 8'h00;
			resource_instance_selector <= 4'h0;
		end else if (ev) begin
			id <= ev_id;
			monitoring_group <= ev_pmg;
			resource_instance_selector <= RIS_KEEP ? ev_ris : 4'h0;
		end else if (sw_wr) begin
			id <= sw_wdata[PEC_ID_LSB +: 16];
			monitoring_group <= sw_wdata[PEC_PMG_LSB +: 8];
			resource_instance_selector <= RIS_KEEP ? sw_wdata[PEC_RIS_LSB +: 4] : 4'h0;
		end
	end

	// Reserved bits read as zero
	assign status = {28'h0, resource_instance_selector, ovr, 3'h0, code, monitoring_group, id};
	// Level request, cleared by writing the code back to zero or by reset
	assign irq = irq_enable & (code != PEC_ERR_NONE);

endmodule

/* verification/pec_error_capture_chk.sv */
`timescale 1ns/1ps
module pec_chk #(
	parameter logic [15:0] HIGHEST_PARTITION_INDEX = 16'h003F,
	parameter logic [7:0] PMG_MAX = 8'h01
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [1:0] reg_space,
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [63:0] reg_wdata,
	input wire logic [63:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic [pec_pkg::PEC_SP_N-1:0] error_irq_enable,
	input wire logic [pec_pkg::PEC_SP_N-1:0] error_irq,
	input wire logic req_valid,
	input wire logic [1:0] req_space,
	input wire logic [15:0] req_partition_id,
	input wire logic [7:0] req_monitoring_group,
	input wire logic fwd_valid,
	input wire logic [15:0] fwd_partition_id,
	input wire logic [7:0] fwd_monitoring_group
);
	import pec_pkg::*;

	////////////////////////////////////////////////////////////
	// One clock domain, nothing judged while in reset
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// Request whose id lies beyond the partition range
	sequence s_bad_req;
		req_valid && req_partition_id > HIGHEST_PARTITION_INDEX;
	endsequence

	////////////////////////////////////////////////////////////
	// Read answer timing and unmapped offsets
	a_rvalid_after_rd: assert property (reg_rd |=> reg_rvalid)
		else $error("read answer missing");
	a_rvalid_no_spur: assert property (reg_rvalid |-> $past(reg_rd))
		else $error("read answer without a read");
	a_unmapped_zero: assert property (
		reg_rd && reg_addr != PEC_ESR_OFFSET |=> reg_rdata == 64'h0)
		else $error("unmapped offset read not zero");

	// Requests always complete; a bad id is forwarded as zero
	a_req_complete: assert property (req_valid |=> fwd_valid)
		else $error("request not forwarded");
	a_bad_req_zero: assert property (
		s_bad_req |=> fwd_valid && fwd_partition_id == 16'h0)
		else $error("bad request id not defaulted");
	a_good_req_copy: assert property (
		req_valid && req_partition_id <= HIGHEST_PARTITION_INDEX &&
		req_monitoring_group <= PMG_MAX
		|=> fwd_partition_id == $past(req_partition_id) &&
		fwd_monitoring_group == $past(req_monitoring_group))
		else $error("good request id altered");
	a_bad_grp_zero: assert property (
		req_valid && req_monitoring_group > PMG_MAX
		|=> fwd_valid && fwd_monitoring_group == 8'h00)
		else $error("bad request group not defaulted");

	// Interrupt raised by an enabled error, never without enable
	a_bad_req_irq: assert property (
		s_bad_req ##0 error_irq_enable[req_space]
		|=> error_irq[$past(req_space)])
		else $error("error interrupt not raised");
	a_irq_gated: assert property (
		(error_irq & ~error_irq_enable) == 4'h0)
		else $error("interrupt raised while disabled");
	a_clear_drops: assert property (
		reg_wr && reg_addr == PEC_ESR_OFFSET &&
		reg_wdata[PEC_CODE_LSB +: 4] == PEC_ERR_NONE &&
		!req_valid |=> !error_irq[$past(reg_space)])
		else $error("interrupt held after clear");
endmodule

/* verification/tb_partition_error_status_capture.sv */
`timescale 1ns/1ps
module tb_partition_error_status_capture;
	import pec_pkg::*;

	logic clk, reset_n, reg_wr, reg_rd, reg_rvalid, fwd_valid;
	logic [1:0] reg_space, sp;
	logic [15:0] reg_addr, id16, fwd_partition_id;
	logic [63:0] reg_wdata, reg_rdata;
	logic [3:0] error_irq_enable, error_irq, resource_instance_selector, f;
	logic [5:0] stb;
	logic [7:0] grp, fwd_monitoring_group;
	int errors, check_count;

	// All event sources share one set of field lines; strobes pick one
	pec_error_capture dut_u (
		.clk, .reset_n, .reg_space, .reg_addr, .reg_wr, .reg_rd,
		.reg_wdata, .reg_rdata, .reg_rvalid, .error_irq_enable, .error_irq,
		.psel_wr(stb[0]), .psel_space(sp), .psel_partition_id(id16),
		.psel_internal(f[0]), .psel_ris(resource_instance_selector),
		.cfg_acc(stb[1]), .cfg_space(sp), .cfg_partition_id(id16),
		.cfg_internal(f[0]), .cfg_ris(resource_instance_selector), .cfg_to_intmap(f[1]),
		.cfg_intmap_wr(f[2]), .cfg_internal_id(id16),
		.cfg_has_control(f[3]),
		.msel_wr(stb[2]), .msel_space(sp), .msel_monitor_selector(id16),
		.msel_ris(resource_instance_selector),
		.mcfg_wr(stb[3]), .mcfg_space(sp), .mcfg_partition_id(id16),
		.mcfg_monitoring_group(grp), .mcfg_ris(resource_instance_selector),
		.macc(stb[4]), .macc_space(sp), .macc_monitor_selector(id16),
		.macc_ris(resource_instance_selector), .macc_has_type(f[3]),
		.req_valid(stb[5]), .req_space(sp), .req_partition_id(id16),
		.req_monitoring_group(grp),
		.fwd_valid, .fwd_partition_id, .fwd_monitoring_group
	);

	////////////////////////////////////////////////////////////
	// Compare and count
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// Read strobe for one cycle, answer sampled after the next edge
	task automatic rd(input logic [1:0] s, input logic [15:0] a,
		input logic [63:0] exp);
		@(posedge clk);
		reg_space <= s;
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk({63'h0, reg_rvalid}, 64'h1);
		chk(reg_rdata, exp);
	endtask

	// Write strobe for one cycle
	task automatic wr(input logic [1:0] s, input logic [15:0] a,
		input logic [63:0] d);
		@(posedge clk);
		reg_space <= s;
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// Clear a space and see its interrupt fall
	task automatic clr(input logic [1:0] s);
		wr(s, 16'h00F8, 64'h0);
		rd(s, 16'h00F8, 64'h0);
		chk({63'h0, error_irq[s]}, 64'h0);
	endtask

	// Fire events, then read back what the space captured
	task automatic tc(input logic [5:0] m, input logic [1:0] s,
		input logic [15:0] i, input logic [7:0] g, input logic [3:0] r,
		input logic [3:0] fl, input logic [3:0] c, input logic o);
		@(posedge clk);
		stb <= m;
		sp <= s;
		id16 <= i;
		// Fields the code must not capture carry noise, so a wrong
		// capture shows up in the read back
		grp <= (g != 8'h00) ? g : 8'h81;
		resource_instance_selector <= (r != 4'h0) ? r : 4'h3;
		f <= fl;
		@(posedge clk);
		stb <= 6'h00;
		rd(s, 16'h00F8, {28'h0, r, o, 3'h0, c, g, i});
		chk({63'h0, error_irq[s]}, {63'h0, error_irq_enable[s]});
	endtask

	// Single place where the run ends
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////
	// Free running clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Run is about 130 cycles; this span of 10000 cycles is far beyond it
	initial begin
		#200000;
		errors++;
		$display("wrong value at %0t: watchdog expired", $time);
		results();
	end

	initial begin
		{reg_wr, reg_rd, reg_space, sp, reg_addr, id16, stb, grp} = '0;
		{reg_wdata, resource_instance_selector, f, errors, check_count} = '0;
		error_irq_enable = 4'hF;
		reset_n = 1'b0;
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		// Empty after reset; a request at the range limits is no error
		for (int s = 0; s < 4; s++) begin
			rd(2'(s), 16'h00F8, 64'h0);
		end
		@(posedge clk);
		stb <= 6'h20;
		id16 <= 16'h003F;
		grp <= 8'h01;
		@(posedge clk);
		stb <= 6'h00;
		rd(2'h0, 16'h00F8, 64'h0);
		$display("test reset done");
		// Four separate instances; other offsets ignore writes
		for (int s = 0; s < 4; s++) begin
			wr(2'(s), 16'h00F8, {48'h0, 16'h00A0 + 16'(s)});
		end
		wr(2'h0, 16'h00F0, {64{1'b1}});
		for (int s = 0; s < 4; s++) begin
			rd(2'(s), 16'h00F8, {48'h0, 16'h00A0 + 16'(s)});
		end
		rd(2'h0, 16'h00F0, 64'h0);
		$display("test frames done");
		// Request errors, the second one overwriting the first
		tc(6'h20, 2'h1, 16'h0040, 8'h01, 4'h0, 4'h8, 4'h2, 1'b0);
		tc(6'h20, 2'h1, 16'h0005, 8'h02, 4'h0, 4'h8, 4'h4, 1'b1);
		clr(2'h1);
		// Two errors at once: partition select wins, flag set
		tc(6'h21, 2'h1, 16'h0045, 8'h00, 4'h1, 4'h8, 4'h1, 1'b1);
		clr(2'h1);
		$display("test request done");
		// Partition select errors
		tc(6'h01, 2'h0, 16'h0050, 8'h00, 4'h1, 4'h8, 4'h1, 1'b0);
		tc(6'h01, 2'h0, 16'h0003, 8'h00, 4'h2, 4'h8, 4'h8, 1'b1);
		// Configuration access errors
		tc(6'h02, 2'h0, 16'h0005, 8'h00, 4'h0, 4'hB, 4'h7, 1'b1);
		tc(6'h02, 2'h0, 16'h0010, 8'h00, 4'h0, 4'hE, 4'h6, 1'b1);
		tc(6'h02, 2'h0, 16'h0002, 8'h00, 4'h1, 4'h1, 4'h9, 1'b1);
		clr(2'h0);
		$display("test partition done");
		// Monitor selector, monitor config and monitor access errors
		tc(6'h04, 2'h3, 16'h0008, 8'h00, 4'h1, 4'h8, 4'h5, 1'b0);
		tc(6'h04, 2'h3, 16'h0002, 8'h00, 4'h3, 4'h8, 4'hA, 1'b1);
		clr(2'h3);
		tc(6'h08, 2'h2, 16'h0041, 8'h01, 4'h1, 4'h8, 4'h3, 1'b0);
		clr(2'h2);
		tc(6'h10, 2'h1, 16'h0003, 8'h00, 4'h1, 4'h0, 4'hB, 1'b0);
		clr(2'h1);
		$display("test monitor done");
		// Disabled space records but stays quiet until enabled
		@(posedge clk);
		error_irq_enable <= 4'hE;
		tc(6'h20, 2'h0, 16'h0070, 8'h01, 4'h0, 4'h8, 4'h2, 1'b0);
		@(posedge clk);
		error_irq_enable <= 4'hF;
		@(posedge clk);
		#1;
		chk({63'h0, error_irq[0]}, 64'h1);
		clr(2'h0);
		$display("test enable done");
		// Reset in mid-run empties a recorded space and quiets it
		tc(6'h20, 2'h2, 16'h0041, 8'h01, 4'h0, 4'h8, 4'h2, 1'b0);
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		rd(2'h2, 16'h00F8, 64'h0);
		chk({63'h0, error_irq[2]}, 64'h0);
		$display("test reset again done");
		results();
	end
endmodule

bind pec_error_capture pec_chk #(
	.HIGHEST_PARTITION_INDEX(HIGHEST_PARTITION_INDEX),
	.PMG_MAX(PMG_MAX)
) chk_u (
	.clk, .reset_n, .reg_space, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
	.reg_rdata, .reg_rvalid, .error_irq_enable, .error_irq, .req_valid,
	.req_space, .req_partition_id, .req_monitoring_group, .fwd_valid,
	.fwd_partition_id, .fwd_monitoring_group
);
